// ==== hdl/tlir_router.sv ====
// Two-level interrupt router: masks, routes and reports peripheral requests
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module tlir_router (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire tlir_pkg::tlir_apb_req_type apb_req,
  output tlir_pkg::tlir_apb_rsp_type apb_rsp,
  // Peripheral level requests, one bit per source position
  input wire logic [tlir_pkg::DATA_W-1:0] src_req,
  // Dedicated requests for the fixed processor inputs
  input wire logic timer_irq,
  input wire logic wireless_irq,
  input wire logic frame_engine_irq,
  // Processor hardware interrupt inputs
  output logic [tlir_pkg::CPU_INT_W-1:0] cpu_int,
  // Block interrupt output
  output logic irq
);
  import tlir_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////
  // Registers and decoded state
  logic [DATA_W-1:0] route_q;
  logic [DATA_W-1:0] mask_q;
  logic global_en_q;
  logic [DATA_W-1:0] raw;
  logic [DATA_W-1:0] low_stat;
  logic [DATA_W-1:0] high_stat;
  logic [DATA_W-1:0] rd_word;
  logic rd_hit;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  //////////////////////////////////////////////////////////////////////////////////////
  // Bus front end
  tlir_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .req(apb_req),
    .rsp(apb_rsp),
    .rd_word(rd_word),
    .rd_hit(rd_hit),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  //////////////////////////////////////////////////////////////////////////////////////
  // Route selection register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= ROUTE_RESET; // [RL17]
    end else if (wr_en && addr_is(wr_addr, OFF_ROUTE)) begin
      route_q <= wr_data & SRC_MASK; // [RL4] [RL10]
    end
  end

  // Per-source masks through separate set and clear registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= MASK_RESET;
    end else if (wr_en && addr_is(wr_addr, OFF_MASK_SET)) begin
      mask_q <= mask_q | (wr_data & SRC_MASK); // [RL12] [RL13]
    end else if (wr_en && addr_is(wr_addr, OFF_MASK_CLR)) begin
      mask_q <= mask_q & ~(wr_data & SRC_MASK); // [RL12] [RL14]
    end
  end

  // Global enable: set by mask-set bit 31, cleared by mask-clear bit 31
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_en_q <= 1'b0;
    end else if (wr_en && addr_is(wr_addr, OFF_MASK_SET) && wr_data[GLOBAL_BIT]) begin
      global_en_q <= 1'b1; // [RL15]
    end else if (wr_en && addr_is(wr_addr, OFF_MASK_CLR) && wr_data[GLOBAL_BIT]) begin
      global_en_q <= 1'b0; // [RL11]
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Status: combinational so rerouting takes effect without delay
  assign raw = src_req & SRC_MASK; // [RL6] [RL16]
  assign low_stat = raw & mask_q & ~route_q; // [RL1] [RL3] [RL5]
  assign high_stat = raw & mask_q & route_q; // [RL2] [RL3] [RL5]

  // Read mux; status registers have no write path
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (apb_req.paddr)
      OFF_LOW_STAT: rd_word = low_stat; // [RL3]
      OFF_HIGH_STAT: rd_word = high_stat; // [RL3]
      OFF_ROUTE: rd_word = route_q; // [RL4]
      OFF_RAW: rd_word = raw; // [RL6]
      OFF_MASK_SET,
      OFF_MASK_CLR: begin
        rd_word = mask_q; // [RL13]
        rd_word[GLOBAL_BIT] = global_en_q; // [RL15]
      end
      default: rd_hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Processor interrupt inputs
  always_comb begin
    cpu_int = '0;
    cpu_int[CPU_INT_LOW] = global_en_q & (|low_stat); // [RL8] [RL11] [RL18]
    cpu_int[CPU_INT_HIGH] = global_en_q & (|high_stat); // [RL7] [RL11] [RL18]
    cpu_int[CPU_INT_RSVD] = 1'b0; // [RL9]
    cpu_int[CPU_INT_FRAME] = frame_engine_irq; // [RL9]
    cpu_int[CPU_INT_WIRELESS] = wireless_irq; // [RL9]
    cpu_int[CPU_INT_TIMER] = timer_irq; // [RL9]
  end

  // Combined level: either routed line active
  assign irq = cpu_int[CPU_INT_LOW] | cpu_int[CPU_INT_HIGH];

endmodule : tlir_router

// ==== hdl/tlir_pkg.sv ====
// Package holding register map, source layout and bus types of the interrupt router
//////////////////////////////////////////////////////////////////////////////////////////
// What this block does
// RL1 - Low status bit: source requesting, unmasked, routed to low line.
// RL2 - High status bit: source requesting, unmasked, routed to high line.
// RL3 - Both masked status registers are read-only; a bit never shows in both.
// RL4 - Route register holds one read-write line selection bit per source.
// RL5 - Changing a route bit moves an active request to the new line at once.
// RL6 - Raw status register shows every request before masking, read-only.
// RL7 - High request line drives processor interrupt input one.
// RL8 - Low request line drives processor interrupt input zero, the lowest priority.
// RL9 - Processor has six inputs; five timer, four wireless, three frame, two reserved.
// RL10 - Source bit positions are the same in every status and route register.
// RL11 - Global disable suppresses both request lines and irq regardless of source masks; timer, wireless and frame inputs pass through.
// RL12 - Separate set and clear registers change masks without read-modify-write.
// RL13 - Mask-set writes of one unmask; zeros ignored; reads return the mask.
// RL14 - Mask-clear writes of one mask the source; zeros ignored.
// RL15 - Bit 31 of mask-set is the global enable; reads report it.
// RL16 - Raw bit reads one whenever the source is active, masked or not.
// RL17 - Route bit zero selects low line, one the high line; reset is low.
// RL18 - Each request line is high when its status has a bit and global enable.
//////////////////////////////////////////////////////////////////////////////////////////
package tlir_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_LOW_STAT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_HIGH_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ROUTE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_RAW = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_MASK_SET = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_MASK_CLR = 8'h38;

  // Global enable position in both mask registers
  localparam int unsigned GLOBAL_BIT = 31;

  // Source bit positions
  localparam int unsigned SRC_SYS_CTRL = 0;
  localparam int unsigned SRC_TIMER0 = 1;
  localparam int unsigned SRC_WATCHDOG = 2;
  localparam int unsigned SRC_BAD_ACCESS = 3;
  localparam int unsigned SRC_PCM = 4;
  localparam int unsigned SRC_SERIAL = 5;
  localparam int unsigned SRC_PARALLEL_IO = 6;
  localparam int unsigned SRC_DMA = 7;
  localparam int unsigned SRC_PERF_CNT = 9;
  localparam int unsigned SRC_AUDIO = 10;
  localparam int unsigned SRC_SERIAL2 = 12;
  localparam int unsigned SRC_ETH_SWITCH = 17;
  localparam int unsigned SRC_USB_HOST = 18;
  localparam int unsigned SRC_USB_DEVICE = 19;

  // Implemented source bits
  localparam logic [DATA_W-1:0] SRC_MASK = 32'h000e_16ff;

  // Reset values
  localparam logic [DATA_W-1:0] ROUTE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;

  // Processor interrupt input indices
  localparam int unsigned CPU_INT_W = 6;
  localparam int unsigned CPU_INT_LOW = 0;
  localparam int unsigned CPU_INT_HIGH = 1;
  localparam int unsigned CPU_INT_RSVD = 2;
  localparam int unsigned CPU_INT_FRAME = 3;
  localparam int unsigned CPU_INT_WIRELESS = 4;
  localparam int unsigned CPU_INT_TIMER = 5;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } tlir_apb_req_type;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } tlir_apb_rsp_type;

endpackage : tlir_pkg

// ==== hdl/tlir_apb_slave.sv ====
// APB slave front end: decodes one access and produces one write strobe with address and data
`timescale 1ns/1ps
module tlir_apb_slave (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire tlir_pkg::tlir_apb_req_type req,
  output tlir_pkg::tlir_apb_rsp_type rsp,
  // Register side
  input wire logic [tlir_pkg::DATA_W-1:0] rd_word,
  input wire logic rd_hit,
  output logic wr_en,
  output logic [tlir_pkg::ADDR_W-1:0] wr_addr,
  output logic [tlir_pkg::DATA_W-1:0] wr_data
);
  import tlir_pkg::*;

  logic [DATA_W-1:0] prdata_q;
  logic pslverr_q;
  logic access;

  // Zero wait states; write takes effect at the access edge, read data is sampled at the setup edge
  assign access = req.psel & req.penable;
  assign wr_en = access & req.pwrite;
  assign wr_addr = req.paddr;
  assign wr_data = req.pwdata;

  // Read data captured in the setup cycle so it stands during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (req.psel && !req.penable) begin
      prdata_q <= (!req.pwrite && rd_hit) ? rd_word : 32'h0000_0000;
      pslverr_q <= ~rd_hit;
    end
  end

  assign rsp.pready = 1'b1;
  assign rsp.pslverr = access & pslverr_q;
  assign rsp.prdata = prdata_q;

endmodule : tlir_apb_slave

// ==== bench/tlir_periph_model.sv ====
// Model of the peripheral sources and fixed processor-side request lines
`timescale 1ns/1ps
module tlir_periph_model (
  // Commands from the bench
  input wire logic [31:0] level_cmd,
  input wire logic [2:0] fixed_cmd,
  // Level requests toward the router
  output logic [tlir_pkg::DATA_W-1:0] src_req,
  output logic timer_irq,
  output logic wireless_irq,
  output logic frame_engine_irq
);
  import tlir_pkg::*;
  // Sources hold a level until the bench changes level_cmd; unused positions are driven as well
  assign src_req = level_cmd;
  assign {timer_irq, wireless_irq, frame_engine_irq} = fixed_cmd;
endmodule : tlir_periph_model

// ==== bench/tlir_router_asserts.sv ====
// Port checker of the interrupt router
`timescale 1ns/1ps
module tlir_router_asserts (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire tlir_pkg::tlir_apb_req_type apb_req,
  input wire tlir_pkg::tlir_apb_rsp_type apb_rsp,
  // Requests and lines
  input wire logic [tlir_pkg::DATA_W-1:0] src_req,
  input wire logic timer_irq,
  input wire logic wireless_irq,
  input wire logic frame_engine_irq,
  input wire logic [tlir_pkg::CPU_INT_W-1:0] cpu_int,
  input wire logic irq
);
  import tlir_pkg::*;
  logic wr_acc;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  AST_FIXED: assert property (cpu_int[5:3] == {timer_irq, wireless_irq, frame_engine_irq})
    else $error("fixed inputs not passed through");
  AST_RSVD: assert property (cpu_int[2] == 1'b0)
    else $error("reserved input driven");
  AST_IRQ: assert property (irq == (cpu_int[0] | cpu_int[1]))
    else $error("irq not the or of both lines");
  AST_IDLE: assert property ((src_req & SRC_MASK) == '0 |-> cpu_int[1:0] == 2'b00)
    else $error("line high with no request");
  AST_GDIS: assert property (wr_acc && apb_req.paddr == OFF_MASK_CLR && apb_req.pwdata[31]
    |=> cpu_int[1:0] == 2'b00) else $error("line high after global disable");
  AST_ALLHI: assert property (wr_acc && apb_req.paddr == OFF_ROUTE
    && (apb_req.pwdata & SRC_MASK) == SRC_MASK |=> !cpu_int[0]) else $error("low line with all high");
  AST_ALLLO: assert property (wr_acc && apb_req.paddr == OFF_ROUTE
    && (apb_req.pwdata & SRC_MASK) == '0 |=> !cpu_int[1]) else $error("high line with all low");
  AST_RDY: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready)
    else $error("access not answered");
endmodule : tlir_router_asserts
bind tlir_router tlir_router_asserts i_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .src_req(src_req), .timer_irq(timer_irq), .wireless_irq(wireless_irq),
  .frame_engine_irq(frame_engine_irq), .cpu_int(cpu_int), .irq(irq));

// ==== bench/tlir_router_tb.sv ====
// Self-checking bench of the interrupt router
`timescale 1ns/1ps
module tlir_router_tb;
  import tlir_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  tlir_apb_req_type apb_req = '0;
  tlir_apb_rsp_type apb_rsp;
  logic [31:0] level_cmd = '0;
  logic [2:0] fixed_cmd = '0;
  logic [DATA_W-1:0] src_req, rd;
  logic timer_irq, wireless_irq, frame_engine_irq, irq, err;
  logic [CPU_INT_W-1:0] cpu_int;
  int err_count = 0;
  int cmp_count = 0;
  localparam logic [31:0] ALL = 32'h000e_16ff;
  localparam logic [31:0] HI = 32'h0008_0001;
  always #50 pclk = ~pclk;
  tlir_periph_model i_src (.level_cmd(level_cmd), .fixed_cmd(fixed_cmd), .src_req(src_req),
    .timer_irq(timer_irq), .wireless_irq(wireless_irq), .frame_engine_irq(frame_engine_irq));
  tlir_router i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .src_req(src_req), .timer_irq(timer_irq), .wireless_irq(wireless_irq),
    .frame_engine_irq(frame_engine_irq), .cpu_int(cpu_int), .irq(irq));
  ////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      test_done();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, '0);
    chk(name, exp, rd);
  endtask : rchk
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("low_stat", OFF_LOW_STAT, '0);
    rchk("route", OFF_ROUTE, '0);
    rchk("mask", OFF_MASK_SET, '0);
    level_cmd <= 32'hffff_ffff;
    fixed_cmd <= 3'b101;
    @(posedge pclk);
    rchk("raw", OFF_RAW, ALL);
    rchk("low_masked", OFF_LOW_STAT, '0);
    apb(1'b1, OFF_MASK_SET, ALL);
    rchk("low_open", OFF_LOW_STAT, ALL);
    chk("lines_gdis", 32'h28, {25'h0, irq, cpu_int});
    apb(1'b1, OFF_MASK_SET, 32'h8000_0000);
    rchk("mask_clr_rd", OFF_MASK_CLR, 32'h800e_16ff);
    chk("lines_low", 32'h69, {25'h0, irq, cpu_int});
    apb(1'b1, OFF_ROUTE, HI);
    rchk("route_rd", OFF_ROUTE, HI);
    rchk("high_stat", OFF_HIGH_STAT, HI);
    rchk("low_rest", OFF_LOW_STAT, ALL & ~HI);
    chk("lines_both", 32'h6b, {25'h0, irq, cpu_int});
    apb(1'b1, OFF_HIGH_STAT, '0);
    rchk("high_ro", OFF_HIGH_STAT, HI);
    apb(1'b1, OFF_MASK_CLR, ALL & ~HI);
    chk("lines_high", 32'h6a, {25'h0, irq, cpu_int});
    rchk("mask_left", OFF_MASK_SET, 32'h8008_0001);
    apb(1'b1, OFF_ROUTE, ALL);
    apb(1'b1, OFF_ROUTE, '0);
    rchk("low_back", OFF_LOW_STAT, HI);
    apb(1'b1, OFF_MASK_CLR, 32'h8000_0000);
    chk("lines_off", 32'h28, {25'h0, irq, cpu_int});
    rchk("low_kept", OFF_LOW_STAT, HI);
    chk("mapped_err", 32'h0, {31'h0, err});
    apb(1'b0, 8'h10, '0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, 8'h10, ALL);
    chk("unmapped_wr_err", 32'h1, {31'h0, err});
    rchk("mask_after_unmapped", OFF_MASK_SET, HI);
    test_done();
  end
endmodule : tlir_router_tb
